// ==== pll_vco_control_regs.sv ====
// Staged PLL and VCO control registers with update commit and readback.
// Assumes the serial port logic on the same clock presents byte writes and reads.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Offset polarity bit 6: 0 pumps up, 1 pumps down, when enabled.
// - Offset magnitude bits 5:4 give half, quarter, eighth, sixteenth of pump current.
// - Offset bit 3 clear means automatic offset; set means bits 6:4 rule.
// - Offset bits 2:0 enable test divide-by-2 of up, down, feedback paths.
// - Antibacklash bits 7:6 select minimum, low, high or maximum period.
// - Antibacklash field ignored, period automatic, unless software enable set.
// - Lock detector bit 0: 0 active, 1 powered down.
// - Calibrate bit 7 starts calibration only with bit 2 set; self clears.
// - Calibration bit 2 clear means automatic calibration, else software triggered.
// - Level control bit 6 set is automatic; clear uses level field.
// - Threshold bits 5:3 reset 110, bit 4 inverted sense.
// - Bit 1 boosts VCO supply by 100 mV.
// - Band bit 0 set selects band field, else automatic band.
// - Amplitude field bits 7:2 resets 10 0000, used without level control.
// - Band field bits 7:1 resets 100 0000.
// - Writes are staged; update bit commits them and self clears.
module pll_vco_control_regs (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_WR_EN,
    input wire logic [7:0] I_WR_ADDR,
    input wire logic [7:0] I_WR_DATA,
    input wire logic I_RD_EN,
    input wire logic [7:0] I_RD_ADDR,
    input wire logic I_RD_BUFFERED,
    input wire logic I_ABL_SW_EN,
    input wire logic I_AUTO_CAL_REQ,
    output logic [7:0] O_RD_DATA,
    output logic O_RD_VALID,
    output logic O_CAL_START,
    output pll_vco_pkg::ctrl_t O_CTRL
);

    // ==========================================================
    // State
    typedef struct packed {
        pll_vco_pkg::regs_t stage;
        pll_vco_pkg::regs_t act;
        pll_vco_pkg::ctrl_t ctrl;
        logic cal_start;
        logic [7:0] rd_data;
        logic rd_valid;
    } state_t;

    // Reset image decode, so the PLL starts in automatic modes
    localparam pll_vco_pkg::ctrl_t CTRL_RST = '{
        offset_auto: 1'b1,
        offset_down: 1'b0,
        offset_shift: pll_vco_pkg::OFS_SHIFT_BASE,
        test_up_div2: 1'b0,
        test_dn_div2: 1'b0,
        test_fb_div2: 1'b0,
        abl_auto: 1'b1,
        abl_period: 2'h0,
        lockdet_pd: 1'b0,
        cal_auto: 1'b1,
        alc_auto: pll_vco_pkg::RST_CAL[pll_vco_pkg::ALC_EN_BIT],
        alc_thresh_rank: pll_vco_pkg::RST_CAL[pll_vco_pkg::THR_HI:pll_vco_pkg::THR_LO]
            ^ pll_vco_pkg::THR_INVERT,
        vco_level: pll_vco_pkg::RST_LEVEL[pll_vco_pkg::LVL_HI:pll_vco_pkg::LVL_LO],
        supply_boost: 1'b0,
        band_auto: 1'b1,
        vco_band: pll_vco_pkg::RST_BAND[pll_vco_pkg::BAND_HI:pll_vco_pkg::BAND_LO]
    };

    state_t st_r;
    state_t st_nxt;
    pll_vco_pkg::ctrl_t map_ctrl;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wdata,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (wdata & mask);
    endfunction : merge

    function automatic logic [7:0] pick(input pll_vco_pkg::regs_t r, input logic [7:0] addr);
        case (addr)
            pll_vco_pkg::ADDR_OFFSET: pick = r.offset;
            pll_vco_pkg::ADDR_ABL: pick = r.abl;
            pll_vco_pkg::ADDR_CAL: pick = r.cal;
            pll_vco_pkg::ADDR_LEVEL: pick = r.level;
            pll_vco_pkg::ADDR_BAND: pick = r.band;
            default: pick = 8'h00;
        endcase
    endfunction : pick

    // ==========================================================
    // Field decode
    pll_vco_map u_map (
        .i_act(st_r.act),
        .i_abl_sw_en(I_ABL_SW_EN),
        .o_ctrl(map_ctrl)
    );

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.cal_start = 1'b0;
        st_nxt.rd_valid = I_RD_EN;
        if (I_RD_EN) begin
            st_nxt.rd_data = I_RD_BUFFERED ? pick(st_r.stage, I_RD_ADDR)
                                           : pick(st_r.act, I_RD_ADDR);
        end
        if (I_WR_EN) begin
            case (I_WR_ADDR)
                pll_vco_pkg::ADDR_OFFSET: begin
                    st_nxt.stage.offset = merge(st_r.stage.offset, I_WR_DATA,
                                                pll_vco_pkg::MASK_OFFSET);
                end
                pll_vco_pkg::ADDR_ABL: begin
                    st_nxt.stage.abl = merge(st_r.stage.abl, I_WR_DATA,
                                             pll_vco_pkg::MASK_ABL);
                end
                pll_vco_pkg::ADDR_CAL: begin
                    st_nxt.stage.cal = merge(st_r.stage.cal, I_WR_DATA,
                                             pll_vco_pkg::MASK_CAL);
                end
                pll_vco_pkg::ADDR_LEVEL: begin
                    st_nxt.stage.level = merge(st_r.stage.level, I_WR_DATA,
                                               pll_vco_pkg::MASK_LEVEL);
                end
                pll_vco_pkg::ADDR_BAND: begin
                    st_nxt.stage.band = merge(st_r.stage.band, I_WR_DATA,
                                              pll_vco_pkg::MASK_BAND);
                end
                pll_vco_pkg::ADDR_UPDATE: begin
                    if (I_WR_DATA[pll_vco_pkg::UPDATE_BIT]) begin
                        st_nxt.act = st_r.stage;
                        st_nxt.act.cal[pll_vco_pkg::CAL_GO_BIT] = 1'b0;
                        st_nxt.stage.cal[pll_vco_pkg::CAL_GO_BIT] = 1'b0;
                        st_nxt.cal_start = st_r.stage.cal[pll_vco_pkg::CAL_GO_BIT]
                            & st_r.stage.cal[pll_vco_pkg::CAL_SW_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
        if (I_AUTO_CAL_REQ && !st_r.act.cal[pll_vco_pkg::CAL_SW_BIT]) begin
            st_nxt.cal_start = 1'b1;
        end
        st_nxt.ctrl = map_ctrl;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            st_r.stage <= {pll_vco_pkg::RST_OFFSET, pll_vco_pkg::RST_ABL,
                           pll_vco_pkg::RST_CAL, pll_vco_pkg::RST_LEVEL,
                           pll_vco_pkg::RST_BAND};
            st_r.act <= {pll_vco_pkg::RST_OFFSET, pll_vco_pkg::RST_ABL,
                         pll_vco_pkg::RST_CAL, pll_vco_pkg::RST_LEVEL,
                         pll_vco_pkg::RST_BAND};
            st_r.ctrl <= CTRL_RST;
            st_r.cal_start <= 1'b0;
            st_r.rd_data <= 8'h00;
            st_r.rd_valid <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_RD_DATA = st_r.rd_data;
    assign O_RD_VALID = st_r.rd_valid;
    assign O_CAL_START = st_r.cal_start;
    assign O_CTRL = st_r.ctrl;

endmodule : pll_vco_control_regs
`default_nettype wire

// ==== pll_vco_control_regs_props.sv ====
// Checker for the PLL and VCO control register bank ports.
// Assumes one clock and binding to pll_vco_control_regs.
`timescale 1ns/1ps
`default_nettype none
module pll_vco_control_regs_props (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_WR_EN,
    input wire logic [7:0] I_WR_ADDR,
    input wire logic [7:0] I_WR_DATA,
    input wire logic I_RD_EN,
    input wire logic [7:0] I_RD_ADDR,
    input wire logic I_RD_BUFFERED,
    input wire logic I_ABL_SW_EN,
    input wire logic I_AUTO_CAL_REQ,
    input wire logic [7:0] O_RD_DATA,
    input wire logic O_RD_VALID,
    input wire logic O_CAL_START,
    input wire pll_vco_pkg::ctrl_t O_CTRL
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // ==========================================================
    // Offset register shadow from the write port
    logic [7:0] ofs_stage_r;
    logic [7:0] ofs_act_r;
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            ofs_stage_r <= pll_vco_pkg::RST_OFFSET;
            ofs_act_r <= pll_vco_pkg::RST_OFFSET;
        end else begin
            if (I_WR_EN && I_WR_ADDR == pll_vco_pkg::ADDR_OFFSET) begin
                ofs_stage_r <= I_WR_DATA & pll_vco_pkg::MASK_OFFSET;
            end
            if (I_WR_EN && I_WR_ADDR == pll_vco_pkg::ADDR_UPDATE && I_WR_DATA[0]) begin
                ofs_act_r <= ofs_stage_r;
            end
        end
    end
    // ==========================================================
    // Properties
    property p_rdv; I_RD_EN |=> O_RD_VALID; endproperty
    a_rdv: assert property (p_rdv) else $error("read valid missing");
    property p_rd05; I_RD_EN && I_RD_ADDR == 8'h05 |=> O_RD_DATA == 8'h00; endproperty
    a_rd05: assert property (p_rd05) else $error("update reads nonzero");
    property p_rd0d; I_RD_EN && I_RD_ADDR == 8'h0d |=> (O_RD_DATA & 8'h3e) == 8'h00; endproperty
    a_rd0d: assert property (p_rd0d) else $error("unused bits nonzero");
    property p_calrd; I_RD_EN && I_RD_ADDR == 8'h0e && !I_RD_BUFFERED |=> !O_RD_DATA[7]; endproperty
    a_calrd: assert property (p_calrd) else $error("calibrate bit stuck");
    property p_pulse; O_CAL_START |=> !O_CAL_START; endproperty
    a_pulse: assert property (p_pulse) else $error("calibration pulse too long");
    property p_auto; I_AUTO_CAL_REQ ##1 O_CTRL.cal_auto |-> O_CAL_START; endproperty
    a_auto: assert property (p_auto) else $error("auto calibration lost");
    property p_abl; I_ABL_SW_EN [*3] |-> !O_CTRL.abl_auto; endproperty
    a_abl: assert property (p_abl) else $error("antibacklash enable ignored");
    property p_ofs;
        1'b1 |=> (O_CTRL.offset_auto == !$past(ofs_act_r[3]))
            && (O_CTRL.offset_down == ($past(ofs_act_r[3]) && $past(ofs_act_r[6])));
    endproperty
    a_ofs: assert property (p_ofs) else $error("offset polarity while auto");
    property p_hold;
        !(I_WR_EN && I_WR_ADDR == 8'h05) [*4] |-> $stable({O_CTRL.vco_band, O_CTRL.vco_level});
    endproperty
    a_hold: assert property (p_hold) else $error("control changed without update");
    c_cal: cover property (O_CAL_START);
    c_buf: cover property (I_RD_EN && I_RD_BUFFERED);
    c_upd: cover property (I_WR_EN && I_WR_ADDR == 8'h05 && I_WR_DATA[0]);
endmodule : pll_vco_control_regs_props
bind pll_vco_control_regs pll_vco_control_regs_props u_props (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_WR_EN(I_WR_EN), .I_WR_ADDR(I_WR_ADDR), .I_WR_DATA(I_WR_DATA), .I_RD_EN(I_RD_EN),
    .I_RD_ADDR(I_RD_ADDR), .I_RD_BUFFERED(I_RD_BUFFERED), .I_ABL_SW_EN(I_ABL_SW_EN),
    .I_AUTO_CAL_REQ(I_AUTO_CAL_REQ), .O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID),
    .O_CAL_START(O_CAL_START), .O_CTRL(O_CTRL));
`default_nettype wire

// ==== pll_vco_control_regs_tb_top.sv ====
// Self-checking bench for the PLL and VCO control register bank.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module pll_vco_control_regs_tb_top;
    logic I_CLK = 1'b0, I_RST_N = 1'b0, I_WR_EN = 1'b0, I_RD_EN = 1'b0;
    logic I_RD_BUFFERED = 1'b0, I_ABL_SW_EN = 1'b0, I_AUTO_CAL_REQ = 1'b0;
    logic [7:0] I_WR_ADDR = 8'h00, I_WR_DATA = 8'h00, I_RD_ADDR = 8'h00, O_RD_DATA, a;
    logic O_RD_VALID, O_CAL_START;
    pll_vco_pkg::ctrl_t O_CTRL;
    logic [7:0] st [5], ac [5];
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h70, 8'h80, 8'h80};
    logic [7:0] msk [5] = '{8'h7f, 8'hc1, 8'hff, 8'hfc, 8'hfe};
    logic [7:0] addrs [7] = '{8'h05, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11};
    logic [15:0] dir [4] = '{16'h0e84, 16'h0501, 16'h0e80, 16'h0501};
    int miscompares = 0, samples_checked = 0;
    always #5 I_CLK = ~I_CLK;
    pll_vco_control_regs u_dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_WR_EN(I_WR_EN),
        .I_WR_ADDR(I_WR_ADDR), .I_WR_DATA(I_WR_DATA), .I_RD_EN(I_RD_EN), .I_RD_ADDR(I_RD_ADDR),
        .I_RD_BUFFERED(I_RD_BUFFERED), .I_ABL_SW_EN(I_ABL_SW_EN),
        .I_AUTO_CAL_REQ(I_AUTO_CAL_REQ), .O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID),
        .O_CAL_START(O_CAL_START), .O_CTRL(O_CTRL));
    // ==========================================================
    // Reference decode and bus task
    function automatic pll_vco_pkg::ctrl_t exp_ctrl(input logic sw);
        logic [7:0] o, b, c;
        o = ac[0];
        b = ac[1];
        c = ac[2];
        return {~o[3], o[3] & o[6], {1'b0, o[5:4]} + 3'h1, o[2:0], ~sw, sw ? b[7:6] : 2'h0,
            b[0], ~c[2], c[6], c[5:3] ^ 3'h2, ac[3][7:2], c[1], ~c[0], ac[4][7:1]};
    endfunction : exp_ctrl
    task automatic op(input logic w, input logic [7:0] ad, input logic [7:0] d,
        input logic q, input logic b);
        logic [7:0] e;
        logic ec;
        int i;
        i = int'(ad) - 12;
        e = (i >= 0 && i < 5) ? (b ? st[i] : ac[i]) : 8'h00;
        ec = (w && ad == 8'h05 && d[0] && st[2][7] && st[2][2]) || (q && !ac[2][2]);
        I_WR_EN <= w;
        I_RD_EN <= !w;
        I_WR_ADDR <= ad;
        I_RD_ADDR <= ad;
        I_WR_DATA <= d;
        I_AUTO_CAL_REQ <= q;
        I_RD_BUFFERED <= b;
        @(posedge I_CLK);
        I_WR_EN <= 1'b0;
        I_RD_EN <= 1'b0;
        I_AUTO_CAL_REQ <= 1'b0;
        if (w && i >= 0 && i < 5) st[i] = d & msk[i];
        if (w && ad == 8'h05 && d[0]) begin
            st[2][7] = 1'b0;
            ac = st;
        end
        @(negedge I_CLK);
        `CHK(O_CAL_START, ec)
        `CHK(O_RD_VALID, !w)
        if (!w) `CHK(O_RD_DATA, e)
        @(posedge I_CLK);
    endtask : op
    task automatic chk_ctrl();
        @(negedge I_CLK);
        `CHK(O_CTRL, exp_ctrl(I_ABL_SW_EN))
        @(posedge I_CLK);
    endtask : chk_ctrl
    task automatic final_report();
        $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        void'($urandom(32'hde6a66e1));
        st = rv;
        ac = rv;
        repeat (12) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        for (int k = 0; k < 10; k++) op(1'b0, 8'h0c + 8'(k % 5), 8'h00, 1'b0, k > 4);
        chk_ctrl();
        for (int k = 0; k < 4; k++) op(1'b1, dir[k][15:8], dir[k][7:0], 1'b0, 1'b0);
        repeat (300) begin
            I_ABL_SW_EN <= 1'($urandom);
            a = addrs[$urandom % 7];
            op(1'b1, a, 8'($urandom), a != 8'h05 && 1'($urandom), 1'b0);
            op(1'b0, addrs[$urandom % 7], 8'h00, 1'($urandom), 1'($urandom));
            chk_ctrl();
        end
        final_report();
    end
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule : pll_vco_control_regs_tb_top
`default_nettype wire

// ==== pll_vco_map.sv ====
// Combinational map from active register image to effective controls.
// Assumes the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module pll_vco_map (
    input wire pll_vco_pkg::regs_t i_act,
    input wire logic i_abl_sw_en,
    output pll_vco_pkg::ctrl_t o_ctrl
);
    always_comb begin
        o_ctrl = '0;
        o_ctrl.offset_auto = ~i_act.offset[pll_vco_pkg::OFS_EN_BIT];
        o_ctrl.offset_down = i_act.offset[pll_vco_pkg::OFS_EN_BIT]
            & i_act.offset[pll_vco_pkg::OFS_POL_BIT];
        o_ctrl.offset_shift = pll_vco_pkg::OFS_SHIFT_BASE
            + {1'b0, i_act.offset[pll_vco_pkg::OFS_MAG_HI:pll_vco_pkg::OFS_MAG_LO]};
        o_ctrl.test_up_div2 = i_act.offset[pll_vco_pkg::OFS_TUP_BIT];
        o_ctrl.test_dn_div2 = i_act.offset[pll_vco_pkg::OFS_TDN_BIT];
        o_ctrl.test_fb_div2 = i_act.offset[pll_vco_pkg::OFS_TFB_BIT];
        o_ctrl.abl_auto = ~i_abl_sw_en;
        o_ctrl.abl_period = i_abl_sw_en
            ? i_act.abl[pll_vco_pkg::ABL_HI:pll_vco_pkg::ABL_LO] : 2'h0;
        o_ctrl.lockdet_pd = i_act.abl[pll_vco_pkg::LDET_PD_BIT];
        o_ctrl.cal_auto = ~i_act.cal[pll_vco_pkg::CAL_SW_BIT];
        o_ctrl.alc_auto = i_act.cal[pll_vco_pkg::ALC_EN_BIT];
        o_ctrl.alc_thresh_rank = i_act.cal[pll_vco_pkg::THR_HI:pll_vco_pkg::THR_LO]
            ^ pll_vco_pkg::THR_INVERT;
        o_ctrl.vco_level = i_act.level[pll_vco_pkg::LVL_HI:pll_vco_pkg::LVL_LO];
        o_ctrl.supply_boost = i_act.cal[pll_vco_pkg::BOOST_BIT];
        o_ctrl.band_auto = ~i_act.cal[pll_vco_pkg::BAND_SW_BIT];
        o_ctrl.vco_band = i_act.band[pll_vco_pkg::BAND_HI:pll_vco_pkg::BAND_LO];
    end
endmodule : pll_vco_map
`default_nettype wire

// ==== pll_vco_pkg.sv ====
// Constants and carrier types for the PLL and VCO control register bank.
// Assumes one 100 MHz clock and a byte-wide register port behind the serial interface.
package pll_vco_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_UPDATE = 8'h05;
    localparam logic [7:0] ADDR_OFFSET = 8'h0c;
    localparam logic [7:0] ADDR_ABL = 8'h0d;
    localparam logic [7:0] ADDR_CAL = 8'h0e;
    localparam logic [7:0] ADDR_LEVEL = 8'h0f;
    localparam logic [7:0] ADDR_BAND = 8'h10;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_ABL = 8'h00;
    localparam logic [7:0] RST_CAL = 8'h70;
    localparam logic [7:0] RST_LEVEL = 8'h80;
    localparam logic [7:0] RST_BAND = 8'h80;

    // ==========================================================
    // Writable bit masks
    localparam logic [7:0] MASK_OFFSET = 8'h7f;
    localparam logic [7:0] MASK_ABL = 8'hc1;
    localparam logic [7:0] MASK_CAL = 8'hff;
    localparam logic [7:0] MASK_LEVEL = 8'hfc;
    localparam logic [7:0] MASK_BAND = 8'hfe;

    // ==========================================================
    // Field positions
    localparam int UPDATE_BIT = 0;
    localparam int OFS_POL_BIT = 6;
    localparam int OFS_MAG_HI = 5;
    localparam int OFS_MAG_LO = 4;
    localparam int OFS_EN_BIT = 3;
    localparam int OFS_TUP_BIT = 2;
    localparam int OFS_TDN_BIT = 1;
    localparam int OFS_TFB_BIT = 0;
    localparam int ABL_HI = 7;
    localparam int ABL_LO = 6;
    localparam int LDET_PD_BIT = 0;
    localparam int CAL_GO_BIT = 7;
    localparam int ALC_EN_BIT = 6;
    localparam int THR_HI = 5;
    localparam int THR_LO = 3;
    localparam int CAL_SW_BIT = 2;
    localparam int BOOST_BIT = 1;
    localparam int BAND_SW_BIT = 0;
    localparam int LVL_HI = 7;
    localparam int LVL_LO = 2;
    localparam int BAND_HI = 7;
    localparam int BAND_LO = 1;
    localparam logic [2:0] THR_INVERT = 3'h2;
    localparam logic [2:0] OFS_SHIFT_BASE = 3'h1;

    // ==========================================================
    // Register images
    typedef struct packed {
        logic [7:0] offset;
        logic [7:0] abl;
        logic [7:0] cal;
        logic [7:0] level;
        logic [7:0] band;
    } regs_t;

    // Effective controls towards the analog PLL and VCO
    typedef struct packed {
        logic offset_auto;
        logic offset_down;
        logic [2:0] offset_shift;
        logic test_up_div2;
        logic test_dn_div2;
        logic test_fb_div2;
        logic abl_auto;
        logic [1:0] abl_period;
        logic lockdet_pd;
        logic cal_auto;
        logic alc_auto;
        logic [2:0] alc_thresh_rank;
        logic [5:0] vco_level;
        logic supply_boost;
        logic band_auto;
        logic [6:0] vco_band;
    } ctrl_t;

endpackage : pll_vco_pkg
